//--- rtl/dac_ctl_params.svh
/*
  Constants of the control pin decoder: pin positions in the synchroniser
  vector, field codes and the start-up defaults of the bus-side settings.
  Assumes it is included by its bare name before the module header.
*/
`ifndef DAC_CTL_PARAMS_SVH
`define DAC_CTL_PARAMS_SVH

// ==========================================================================
// pin positions inside the synchronised pin vector
`define PIN_COUNT 9
`define PIN_STATIC 0
`define PIN_I2C 1
`define PIN_MODE_LINE 2
`define PIN_DATA_LINE 3
`define PIN_CLOCK_LINE 4
`define PIN_CHANNEL 5
`define PIN_CLOCK_SRC 6
`define PIN_DAC_SRC 7
`define PIN_MUTE 8

// ==========================================================================
// interface format codes
`define FMT_I2S 2'h0
`define FMT_LSB16 2'h1
`define FMT_LSB20 2'h2
`define FMT_LSB24 2'h3

// pre-emphasis codes
`define PREEM_NONE 2'h0
`define PREEM_32K0 2'h1
`define PREEM_44K1 2'h2
`define PREEM_48K0 2'h3

// ==========================================================================
// start-up defaults of the bus-side settings
`define DEF_FORMAT 2'h0
`define DEF_CHANNEL 1'h0
`define DEF_CLOCK_SRC 1'h0
`define DEF_DAC_SRC 1'h1
`define DEF_MUTE_BIT 1'h1
`define MUTE_REG_ADDR 7'h13

`endif

//--- rtl/dac_ctl_pkg.sv
/*
  Types of the control pin decoder: control mode, configuration, status and
  serial-bus routing carriers. Assumes nothing beyond a SystemVerilog tool.
*/
`default_nettype none

package dac_ctl_pkg;

  // ========================================================================
  // control mode, gray along three-wire -> i2c -> static
  typedef enum logic [1:0] {
    MODE_THREE_WIRE = 2'h0,
    MODE_I2C = 2'h1,
    MODE_STATIC = 2'h3
  } ctl_mode_t;

  // data path configuration
  typedef struct packed {
    logic [1:0] format;
    logic spdif_channel_select;
    logic clock_source_select;
    logic dac_source_select;
  } audio_cfg_t;

  // serial-bus lines handed to a protocol engine
  typedef struct packed {
    logic data_line;
    logic clock_line;
    logic mode_line;
  } bus_route_t;

  // whole state of the decoder
  typedef struct packed {
    ctl_mode_t mode;
    audio_cfg_t cfg;
    logic soft_mute;
    logic soft_mute_bit;
    logic load_defaults;
    logic pcm_detect_status;
    logic lock;
    logic preemphasis_status_hi;
    logic preemphasis_status_lo;
    bus_route_t tw_route;
    bus_route_t i2c_route;
    logic data_out;
    logic data_oe;
  } ctl_state_t;

endpackage

`default_nettype wire

//--- rtl/pin_sync.sv
/*
  Three-flop pin synchroniser with agreement filter.
  Assumes asynchronous pins; output moves once stages two and three agree.
*/
`default_nettype none

module pin_sync
  import dac_ctl_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } sync_t;

  sync_t st;
  sync_t next_st;

  // ========================================================================
  // shift chain; stable follows only agreeing bits
  always_comb begin
    next_st = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.stable[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.stable;

endmodule

`default_nettype wire

//--- rtl/dac_control_pin_decoder.sv
/*
  Control-mode selection, static configuration pin decoding, soft mute and
  status pin drive of an IEC 60958 receiver and audio DAC.
  Assumes pins arrive asynchronously; lock, PCM and pre-emphasis flags and
  the register-side settings come from logic on the same clock.
*/
// Overview of operation
// - static-mode select high: configuration comes from dedicated pins.
// - static-mode select low: configuration comes over a serial bus.
// - serial mode: i2c select low picks three-wire, high picks i2c.
// - static format pins: 00 i2s, 01/10/11 lsb-justified 16/20/24 bits.
// - static channel pin picks spdif input 0 when low, 1 when high.
// - clock pin low follows spdif rate as master, high follows data input.
// - source pin low feeds dac from data interface, high from decoder.
// - pcm detect high for pcm, low for non-pcm or burst, every mode.
// - lock high only when both locks held and pcm seen.
// - pre-emphasis pins 00 none, 01/10/11 at 32.0/44.1/48.0 kHz.
// - serial mode: non-pin settings reset to their start-up defaults.
// - serial modes: start-up mute released only by the mute bit.
// - i2c uses data/clock pins; three-wire uses data, clock, mode.
// - serial modes keep reset, mute pin and all status pins alive.
// - mute pin high always forces soft mute in every mode.
`default_nettype none

`include "dac_ctl_params.svh"

module dac_control_pin_decoder
  import dac_ctl_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic STATIC_MODE_SELECT,
  input wire logic I2C_MODE_SELECT,
  input wire logic BUS_MODE_LINE,
  input wire logic BUS_DATA_LINE_I,
  output logic BUS_DATA_LINE_O,
  output logic BUS_DATA_LINE_OE,
  input wire logic BUS_CLOCK_LINE,
  input wire logic SPDIF_CHANNEL_SELECT,
  input wire logic CLOCK_SOURCE_SELECT,
  input wire logic DAC_SOURCE_SELECT,
  input wire logic MUTE,
  input wire audio_cfg_t REG_CFG,
  input wire logic REG_MUTE_WRITE,
  input wire logic REG_MUTE_VALUE,
  input wire logic TW_DATA_OUT,
  input wire logic TW_DATA_OE,
  input wire logic I2C_SDA_LOW,
  input wire logic PLL_LOCKED,
  input wire logic DECODER_LOCKED,
  input wire logic PCM_SEEN,
  input wire logic BURST_SEEN,
  input wire logic [1:0] PREEMPH_CODE,
  output ctl_mode_t CONTROL_MODE,
  output audio_cfg_t AUDIO_CFG,
  output logic SOFT_MUTE,
  output logic SOFT_MUTE_BIT,
  output logic LOAD_DEFAULTS,
  output logic PCM_DETECT_STATUS,
  output logic LOCK,
  output logic PREEMPHASIS_STATUS_HI,
  output logic PREEMPHASIS_STATUS_LO,
  output bus_route_t TW_ROUTE,
  output bus_route_t I2C_ROUTE
);

  // ========================================================================
  // pin synchronisation
  logic [`PIN_COUNT-1:0] raw_pins;
  logic [`PIN_COUNT-1:0] pins;

  assign raw_pins = {MUTE, DAC_SOURCE_SELECT, CLOCK_SOURCE_SELECT,
                     SPDIF_CHANNEL_SELECT, BUS_CLOCK_LINE, BUS_DATA_LINE_I,
                     BUS_MODE_LINE, I2C_MODE_SELECT, STATIC_MODE_SELECT};

  pin_sync #(
    .W(`PIN_COUNT)
  ) u_pin_sync (
    .clk(CLK),
    .rst(RST),
    .pin(raw_pins),
    .level(pins)
  );

  // ========================================================================
  // helpers
  function automatic ctl_mode_t decode_mode(input logic stat,
                                            input logic i2c);
    if (stat) begin
      decode_mode = MODE_STATIC;
    end else if (i2c) begin
      decode_mode = MODE_I2C;
    end else begin
      decode_mode = MODE_THREE_WIRE;
    end
  endfunction

  function automatic audio_cfg_t default_cfg();
    default_cfg.format = `DEF_FORMAT;
    default_cfg.spdif_channel_select = `DEF_CHANNEL;
    default_cfg.clock_source_select = `DEF_CLOCK_SRC;
    default_cfg.dac_source_select = `DEF_DAC_SRC;
  endfunction

  // ========================================================================
  // state
  ctl_state_t st;
  ctl_state_t next_st;
  ctl_mode_t new_mode;
  logic mode_change;
  logic pcm_now;

  always_comb begin
    new_mode = decode_mode(pins[`PIN_STATIC], pins[`PIN_I2C]);
    mode_change = (new_mode != st.mode);
    pcm_now = PCM_SEEN & ~BURST_SEEN;
    next_st = st;
    next_st.mode = new_mode;
    next_st.load_defaults = 1'b0;

    // configuration source per mode
    case (new_mode)
      MODE_STATIC: begin
        next_st.cfg.format = {pins[`PIN_MODE_LINE],
                              pins[`PIN_DATA_LINE]};
        next_st.cfg.spdif_channel_select = pins[`PIN_CHANNEL];
        next_st.cfg.clock_source_select = pins[`PIN_CLOCK_SRC];
        next_st.cfg.dac_source_select = pins[`PIN_DAC_SRC];
      end
      MODE_I2C, MODE_THREE_WIRE: begin
        if (mode_change) begin
          next_st.cfg = default_cfg();
          next_st.load_defaults = 1'b1;
        end else begin
          next_st.cfg = REG_CFG;
        end
      end
      default: begin
        next_st.cfg = default_cfg();
      end
    endcase

    // start-up mute bit: set on entry, cleared only by a register write
    if (new_mode == MODE_STATIC) begin
      next_st.soft_mute_bit = `DEF_MUTE_BIT;
    end else if (mode_change) begin
      next_st.soft_mute_bit = `DEF_MUTE_BIT;
    end else if (REG_MUTE_WRITE) begin
      next_st.soft_mute_bit = REG_MUTE_VALUE;
    end

    // mute pin always wins; bus bit adds in serial modes
    next_st.soft_mute = pins[`PIN_MUTE] |
                        ((new_mode != MODE_STATIC) &
                         next_st.soft_mute_bit);

    // status pins, driven in every mode
    next_st.pcm_detect_status = pcm_now;
    next_st.lock = PLL_LOCKED & DECODER_LOCKED & pcm_now;
    next_st.preemphasis_status_hi = PREEMPH_CODE[1];
    next_st.preemphasis_status_lo = PREEMPH_CODE[0];

    // serial line routing; idle engines see a quiet bus
    next_st.tw_route = '0;
    next_st.i2c_route = '{data_line: 1'b1, clock_line: 1'b1,
                          mode_line: 1'b0};
    next_st.data_out = 1'b0;
    next_st.data_oe = 1'b0;
    case (new_mode)
      MODE_THREE_WIRE: begin
        next_st.tw_route.data_line = pins[`PIN_DATA_LINE];
        next_st.tw_route.clock_line = pins[`PIN_CLOCK_LINE];
        next_st.tw_route.mode_line = pins[`PIN_MODE_LINE];
        next_st.data_out = TW_DATA_OUT;
        next_st.data_oe = TW_DATA_OE;
      end
      MODE_I2C: begin
        next_st.i2c_route.data_line = pins[`PIN_DATA_LINE];
        next_st.i2c_route.clock_line = pins[`PIN_CLOCK_LINE];
        next_st.data_out = 1'b0; // open drain: only pulls low
        next_st.data_oe = I2C_SDA_LOW;
      end
      MODE_STATIC: begin
        next_st.data_oe = 1'b0; // data pin is a format strap
      end
      default: begin
        next_st.data_oe = 1'b0;
      end
    endcase
  end

  // ========================================================================
  // state register; reset pin holds everything at rest
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st <= '{mode: MODE_THREE_WIRE,
              cfg: '{format: `DEF_FORMAT,
                     spdif_channel_select: `DEF_CHANNEL,
                     clock_source_select: `DEF_CLOCK_SRC,
                     dac_source_select: `DEF_DAC_SRC},
              soft_mute: 1'b1,
              soft_mute_bit: `DEF_MUTE_BIT,
              load_defaults: 1'b0,
              pcm_detect_status: 1'b0,
              lock: 1'b0,
              preemphasis_status_hi: 1'b0,
              preemphasis_status_lo: 1'b0,
              tw_route: '0,
              i2c_route: '{data_line: 1'b1, clock_line: 1'b1,
                           mode_line: 1'b0},
              data_out: 1'b0,
              data_oe: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ========================================================================
  // outputs straight from the state register
  assign CONTROL_MODE = st.mode;
  assign AUDIO_CFG = st.cfg;
  assign SOFT_MUTE = st.soft_mute;
  assign SOFT_MUTE_BIT = st.soft_mute_bit;
  assign LOAD_DEFAULTS = st.load_defaults;
  assign PCM_DETECT_STATUS = st.pcm_detect_status;
  assign LOCK = st.lock;
  assign PREEMPHASIS_STATUS_HI = st.preemphasis_status_hi;
  assign PREEMPHASIS_STATUS_LO = st.preemphasis_status_lo;
  assign TW_ROUTE = st.tw_route;
  assign I2C_ROUTE = st.i2c_route;
  assign BUS_DATA_LINE_O = st.data_out;
  assign BUS_DATA_LINE_OE = st.data_oe;

endmodule

`default_nettype wire

//--- testbench/dac_ctl_chk.sv
/*
  Checker of the control pin decoder, bound to its top module.
  Assumes the decoder's port names and the package types.
*/
`default_nettype none
`include "dac_ctl_params.svh"

module dac_ctl_chk
  import dac_ctl_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic MUTE,
  input wire logic REG_MUTE_WRITE,
  input wire logic REG_MUTE_VALUE,
  input wire logic I2C_SDA_LOW,
  input wire logic PLL_LOCKED,
  input wire logic DECODER_LOCKED,
  input wire logic PCM_SEEN,
  input wire logic BURST_SEEN,
  input wire logic [1:0] PREEMPH_CODE,
  input wire ctl_mode_t CONTROL_MODE,
  input wire audio_cfg_t AUDIO_CFG,
  input wire logic SOFT_MUTE,
  input wire logic SOFT_MUTE_BIT,
  input wire logic LOAD_DEFAULTS,
  input wire logic PCM_DETECT_STATUS,
  input wire logic LOCK,
  input wire logic PREEMPHASIS_STATUS_HI,
  input wire logic PREEMPHASIS_STATUS_LO,
  input wire logic BUS_DATA_LINE_O,
  input wire logic BUS_DATA_LINE_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  logic serial;

  // ========================================================================
  // status pins
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  assign serial = CONTROL_MODE != MODE_STATIC;
  preem_follow_a: assert property (
    !$past(RST) |-> {PREEMPHASIS_STATUS_HI, PREEMPHASIS_STATUS_LO}
    == $past(PREEMPH_CODE)) else $error("pre-emphasis status wrong");
  pcm_detect_a: assert property (
    !$past(RST) |-> PCM_DETECT_STATUS == $past(PCM_SEEN && !BURST_SEEN))
    else $error("pcm detect wrong");
  lock_cause_a: assert property (
    LOCK |-> $past(PLL_LOCKED && DECODER_LOCKED && PCM_SEEN && !BURST_SEEN))
    else $error("lock without cause");

  // ========================================================================
  // mute
  mute_pin_a: assert property (MUTE [*8] |=> SOFT_MUTE)
    else $error("mute pin ignored");
  static_unmute_a: assert property (
    (CONTROL_MODE == MODE_STATIC && !MUTE) [*8] |=> !SOFT_MUTE || serial)
    else $error("static mode muted without pin");
  bit_write_a: assert property (
    REG_MUTE_WRITE && serial |=> $changed(CONTROL_MODE)
    || SOFT_MUTE_BIT == $past(REG_MUTE_VALUE)) else $error("mute bit lost");
  unmute_cause_a: assert property (
    $fell(SOFT_MUTE_BIT) |-> $past(REG_MUTE_WRITE && !REG_MUTE_VALUE))
    else $error("mute bit cleared without write");
  bit_mutes_a: assert property (
    serial && SOFT_MUTE_BIT |-> SOFT_MUTE) else $error("mute bit ignored");

  // ========================================================================
  // defaults and data pin
  defaults_load_a: assert property (
    LOAD_DEFAULTS |-> serial && SOFT_MUTE_BIT && AUDIO_CFG ==
    {`DEF_FORMAT, `DEF_CHANNEL, `DEF_CLOCK_SRC, `DEF_DAC_SRC})
    else $error("defaults not loaded");
  load_pulse_a: assert property (LOAD_DEFAULTS |=> !LOAD_DEFAULTS)
    else $error("default load too long");
  i2c_drive_a: assert property (
    CONTROL_MODE == MODE_I2C && $past(CONTROL_MODE) == MODE_I2C |->
    !BUS_DATA_LINE_O && BUS_DATA_LINE_OE == $past(I2C_SDA_LOW))
    else $error("sda drive wrong");
  static_release_a: assert property (
    $stable(CONTROL_MODE) && CONTROL_MODE == MODE_STATIC |-> !BUS_DATA_LINE_OE)
    else $error("data pin driven in static mode");
  cover property (LOAD_DEFAULTS);
  cover property ($fell(SOFT_MUTE_BIT));
  cover property (LOCK);
  cover property (CONTROL_MODE == MODE_I2C && BUS_DATA_LINE_OE);
endmodule

bind dac_control_pin_decoder dac_ctl_chk dac_ctl_chk_i (.*);

`default_nettype wire

//--- testbench/strap_host.sv
/*
  Board strap and bus host model: holds the pin levels asked for by the
  bench and resolves the shared data wire. Assumes one clock.
*/
`default_nettype none
`include "dac_ctl_params.svh"

module strap_host
(
  input wire logic clk,
  input wire logic [8:0] strap,
  input wire logic dut_o,
  input wire logic dut_oe,
  output logic [8:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] held;

  // pins change only just after a clock edge
  always_ff @(posedge clk) begin
    held <= strap;
  end

  // device drive wins; a released line shows the held host level
  always_comb begin
    pin = held;
    if (dut_oe) pin[`PIN_DATA_LINE] = dut_o;
  end
endmodule

`default_nettype wire

//--- testbench/tb.sv
/*
  Self-checking bench of the control pin decoder with random status flags.
  Assumes the design, its package, header, checker and strap host model.
*/
`default_nettype none
`include "dac_ctl_params.svh"

module tb
  import dac_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic REG_MUTE_WRITE, REG_MUTE_VALUE, TW_DATA_OUT, TW_DATA_OE, I2C_SDA_LOW;
  logic PLL_LOCKED, DECODER_LOCKED, PCM_SEEN, BURST_SEEN;
  logic [1:0] PREEMPH_CODE;
  audio_cfg_t REG_CFG, AUDIO_CFG;
  logic BUS_DATA_LINE_O, BUS_DATA_LINE_OE, SOFT_MUTE, SOFT_MUTE_BIT, LOCK;
  logic LOAD_DEFAULTS, PCM_DETECT_STATUS;
  logic PREEMPHASIS_STATUS_HI, PREEMPHASIS_STATUS_LO;
  ctl_mode_t CONTROL_MODE;
  bus_route_t TW_ROUTE, I2C_ROUTE;
  logic [8:0] strap, pin, v;
  logic [31:0] seed = 32'h0000774C;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  int n_load = 0;
  int l0;

  // ========================================================================
  // design and far side
  dac_control_pin_decoder dac_control_pin_decoder_i (.*,
    .STATIC_MODE_SELECT(pin[`PIN_STATIC]), .I2C_MODE_SELECT(pin[`PIN_I2C]),
    .BUS_MODE_LINE(pin[`PIN_MODE_LINE]), .BUS_DATA_LINE_I(pin[`PIN_DATA_LINE]),
    .BUS_CLOCK_LINE(pin[`PIN_CLOCK_LINE]), .MUTE(pin[`PIN_MUTE]),
    .SPDIF_CHANNEL_SELECT(pin[`PIN_CHANNEL]),
    .CLOCK_SOURCE_SELECT(pin[`PIN_CLOCK_SRC]),
    .DAC_SOURCE_SELECT(pin[`PIN_DAC_SRC]));
  strap_host strap_host_i (.clk(CLK), .strap(strap), .dut_o(BUS_DATA_LINE_O),
    .dut_oe(BUS_DATA_LINE_OE), .pin(pin));

  // ========================================================================
  // clock, hang limit and default-load pulse count
  always #20 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish();
    end
  end
  always @(posedge CLK) if (LOAD_DEFAULTS === 1'b1) n_load <= n_load + 1;

  // ========================================================================
  // helpers and expectations
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [4:0] cfg_exp(input logic [8:0] p);
    return {p[2], p[3], p[5], p[6], p[7]};
  endfunction
  function automatic logic [3:0] status_exp(input logic [5:0] f);
    return {f[3] & ~f[2], &f[5:3] & ~f[2], f[1:0]};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge CLK);
    @(negedge CLK);
  endtask
  task automatic set_pins(input logic [8:0] p);
    @(posedge CLK);
    strap <= p;
    REG_CFG <= 5'(rnd());
    settle(8);
  endtask
  task automatic mute_write(input logic val);
    @(posedge CLK);
    REG_MUTE_WRITE <= 1'b1;
    REG_MUTE_VALUE <= val;
    @(posedge CLK);
    REG_MUTE_WRITE <= 1'b0;
    settle(0);
  endtask
  task automatic status_round(input int n);
    logic [5:0] f;
    repeat (n) begin
      f = 6'(rnd());
      if (f[0]) f[5:3] = 3'h7;
      @(posedge CLK);
      {PLL_LOCKED, DECODER_LOCKED, PCM_SEEN, BURST_SEEN, PREEMPH_CODE} <= f;
      settle(1);
      check(8'({PCM_DETECT_STATUS, LOCK, PREEMPHASIS_STATUS_HI,
        PREEMPHASIS_STATUS_LO}), 8'(status_exp(f)),
        "status");
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ========================================================================
  // main sequence
  initial begin
    strap = '0;
    REG_CFG = '0;
    {REG_MUTE_WRITE, REG_MUTE_VALUE, TW_DATA_OUT, TW_DATA_OE, I2C_SDA_LOW,
     PLL_LOCKED, DECODER_LOCKED, PCM_SEEN, BURST_SEEN, PREEMPH_CODE} = '0;
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      v = 9'(rnd()) & 9'h1E3 | 9'h001;
      {v[`PIN_MODE_LINE], v[`PIN_DATA_LINE]} = 2'(k);
      set_pins(v);
      check(8'(CONTROL_MODE), 8'(MODE_STATIC), "mode");
      check(8'(AUDIO_CFG), 8'(cfg_exp(v)), "cfg");
      check(8'(SOFT_MUTE), 8'(v[`PIN_MUTE]), "mute");
    end
    mute_write(1'b0);
    check(8'(SOFT_MUTE_BIT), 8'h01, "bit in static");
    status_round(30);
    l0 = n_load;
    v = 9'h00A;
    set_pins(v);
    check(8'(CONTROL_MODE), 8'(MODE_I2C), "mode");
    check(8'(n_load - l0), 8'h01, "loads");
    check(8'(SOFT_MUTE), 8'h01, "startup mute");
    check(8'(AUDIO_CFG), 8'(REG_CFG), "bus cfg");
    check(8'({I2C_ROUTE, TW_ROUTE}), 8'({v[`PIN_DATA_LINE],
      v[`PIN_CLOCK_LINE], 4'h0}), "i2c route");
    mute_write(1'b0);
    check(8'({SOFT_MUTE, SOFT_MUTE_BIT}), 8'h00, "unmute");
    set_pins(v | 9'h100);
    check(8'(SOFT_MUTE), 8'h01, "pin mute");
    @(posedge CLK);
    I2C_SDA_LOW <= 1'b1;
    settle(2);
    check(8'({BUS_DATA_LINE_O, BUS_DATA_LINE_OE, pin[3]}), 8'h02,
      "sda");
    status_round(30);
    v = 9'(rnd()) & 9'h014 | 9'h008;
    @(posedge CLK);
    {TW_DATA_OUT, TW_DATA_OE} <= 2'(rnd());
    set_pins(v);
    check(8'(CONTROL_MODE), 8'(MODE_THREE_WIRE), "mode");
    check(8'({TW_ROUTE.clock_line, TW_ROUTE.mode_line, I2C_ROUTE}),
      8'({v[`PIN_CLOCK_LINE], v[`PIN_MODE_LINE], 3'h6}), "route");
    check(8'({BUS_DATA_LINE_O, BUS_DATA_LINE_OE}),
      8'({TW_DATA_OUT, TW_DATA_OE}), "tw drive");
    status_round(30);
    @(posedge CLK);
    RST <= 1'b1;
    settle(1);
    check(8'({CONTROL_MODE, SOFT_MUTE, SOFT_MUTE_BIT, LOAD_DEFAULTS}),
      8'({MODE_THREE_WIRE, 3'h6}), "reset");
    @(posedge CLK);
    RST <= 1'b0;
    set_pins(9'h081);
    check(8'(CONTROL_MODE), 8'(MODE_STATIC), "mode again");
    tally_and_finish();
  end
endmodule

`default_nettype wire
